/* ccpcmp_compare_unit.sv */
// One compare channel: registers, match actions, trigger and pin routing.
// Assumes a 16-bit timer outside that supplies its count and a tick
// enable per timer clock edge, and accepts a reset request.

module ccpcmp_compare_unit
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_n_i,
  // Register port
  input  wire ccpcmp_pkg::ccpcmp_req_t reg_req_i,
  output logic [7:0]                  reg_rdata_o,
  // Timer
  input  wire ccpcmp_pkg::ccpcmp_tmr_t timer_i,
  output logic                        timer_reset_o,
  output logic                        timer_ovf_from_trig_o,
  // Converter
  input  wire logic                   adc_enable_i,
  output logic                        adc_start_o,
  // Interrupt flag
  input  wire logic                   flag_clear_i,
  output logic                        channel_interrupt_flag_o,
  // Pin
  input  wire logic                   pin_direction_bit_i,
  input  wire logic                   port_data_i,
  output logic                        pin_main_o,
  output logic                        pin_main_oe_o,
  output logic                        pin_alt_o,
  output logic                        pin_alt_oe_o,
  output logic                        special_trigger_o
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic ccpcmp_pkg::ccpcmp_act_t decode_mode(input logic [3:0] mode);
    ccpcmp_pkg::ccpcmp_act_t act;
    act = ccpcmp_pkg::CCPCMP_ACT_NONE;
    case (mode)
      ccpcmp_pkg::MODE_TOGGLE,
      ccpcmp_pkg::MODE_SET,
      ccpcmp_pkg::MODE_CLEAR:    act = ccpcmp_pkg::CCPCMP_ACT_PIN;
      ccpcmp_pkg::MODE_SOFT_INT: act = ccpcmp_pkg::CCPCMP_ACT_INT;
      ccpcmp_pkg::MODE_SPECIAL:  act = ccpcmp_pkg::CCPCMP_ACT_TRIG;
      default:                   act = ccpcmp_pkg::CCPCMP_ACT_NONE;
    endcase
    return act;
  endfunction : decode_mode

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] control_q;
  logic [7:0] cmp_low_q;
  logic [7:0] cmp_high_q;
  logic [7:0] alt_pin_q;
  logic       wr_control;

  assign wr_control = reg_req_i.wr && (reg_req_i.addr == ccpcmp_pkg::ADDR_CONTROL);

  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      control_q  <= ccpcmp_pkg::CONTROL_RESET;
      cmp_low_q  <= ccpcmp_pkg::CMP_RESET;
      cmp_high_q <= ccpcmp_pkg::CMP_RESET;
      alt_pin_q  <= ccpcmp_pkg::ALT_PIN_RESET;
    end
    else if (reg_req_i.wr)
    begin
      case (reg_req_i.addr)
        ccpcmp_pkg::ADDR_CONTROL:  control_q  <= reg_req_i.wdata & ccpcmp_pkg::CONTROL_MASK;
        ccpcmp_pkg::ADDR_CMP_LOW:  cmp_low_q  <= reg_req_i.wdata;
        ccpcmp_pkg::ADDR_CMP_HIGH: cmp_high_q <= reg_req_i.wdata;
        ccpcmp_pkg::ADDR_ALT_PIN:  alt_pin_q  <= reg_req_i.wdata & ccpcmp_pkg::ALT_PIN_MASK;
        default:                   control_q  <= control_q;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      reg_rdata_o <= 8'h00;
    else if (reg_req_i.rd)
    begin
      case (reg_req_i.addr)
        ccpcmp_pkg::ADDR_CONTROL:  reg_rdata_o <= control_q & ccpcmp_pkg::CONTROL_MASK;
        ccpcmp_pkg::ADDR_CMP_LOW:  reg_rdata_o <= cmp_low_q;
        ccpcmp_pkg::ADDR_CMP_HIGH: reg_rdata_o <= cmp_high_q;
        ccpcmp_pkg::ADDR_ALT_PIN:  reg_rdata_o <= alt_pin_q;
        default:                   reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Match detection
  // ----------------------------------------------------------------
  logic [3:0]              mode;
  ccpcmp_pkg::ccpcmp_act_t act;
  logic                    match;
  logic                    match_q;
  logic                    match_rise;

  assign mode = control_q[ccpcmp_pkg::MODE_MSB:ccpcmp_pkg::MODE_LSB];
  assign act  = decode_mode(mode);

  // Timer clocked from the raw system clock cannot be recognized
  ccpcmp_matcher u_matcher
  (
    .cmp_value_i   ({cmp_high_q, cmp_low_q}),
    .timer_count_i (timer_i.count),
    .enable_i      ((act != ccpcmp_pkg::CCPCMP_ACT_NONE) && !timer_i.sys_clk_src),
    .match_o       (match)
  );

  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      match_q <= 1'b0;
    else
      match_q <= match; // history lives on sys_clk_i; nothing is promised while it stops
  end

  // One action per match: the count may hold for many system cycles
  assign match_rise = match && !match_q;

  // ----------------------------------------------------------------
  // Interrupt flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      channel_interrupt_flag_o <= 1'b0;
    else if (match_rise)
      channel_interrupt_flag_o <= 1'b1; // set wins over clear
    else if (flag_clear_i)
      channel_interrupt_flag_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Compare output latch
  // ----------------------------------------------------------------
  logic out_latch_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      out_latch_q <= 1'b0;
    else if (wr_control && (reg_req_i.wdata == 8'h00))
      out_latch_q <= 1'b0;
    else if (match_rise)
    begin
      case (mode)
        ccpcmp_pkg::MODE_TOGGLE: out_latch_q <= !out_latch_q;
        ccpcmp_pkg::MODE_SET:    out_latch_q <= 1'b1;
        ccpcmp_pkg::MODE_CLEAR:  out_latch_q <= 1'b0;
        default:                 out_latch_q <= out_latch_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Special event trigger
  // ----------------------------------------------------------------
  logic trig_pending_q;
  logic trig_now;

  assign trig_now = match_rise && (act == ccpcmp_pkg::CCPCMP_ACT_TRIG);

  // Combinational so the trigger appears in the match cycle itself
  assign special_trigger_o = trig_now;
  assign adc_start_o       = trig_now && adc_enable_i;

  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      trig_pending_q <= 1'b0;
    else if (trig_now)
      trig_pending_q <= 1'b1;
    else if (timer_i.tick || !match)
      trig_pending_q <= 1'b0;
  end

  // Reset lands on the next timer clock edge, only while still equal
  assign timer_reset_o         = trig_pending_q && match && timer_i.tick;
  assign timer_ovf_from_trig_o = 1'b0;

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  logic pin_val;
  logic pin_oe;
  logic use_alt;

  // Port logic keeps the pin in interrupt-only and trigger modes
  assign pin_val = (act == ccpcmp_pkg::CCPCMP_ACT_PIN) ? out_latch_q : port_data_i;
  assign pin_oe  = !pin_direction_bit_i;
  assign use_alt = alt_pin_q[ccpcmp_pkg::ALT_SEL_BIT];

  assign pin_main_o    = use_alt ? 1'b0 : pin_val;
  assign pin_main_oe_o = use_alt ? 1'b0 : pin_oe;
  assign pin_alt_o     = use_alt ? pin_val : 1'b0;
  assign pin_alt_oe_o  = use_alt ? pin_oe : 1'b0;

endmodule : ccpcmp_compare_unit

/* ccpcmp_pkg.sv */
// Package for the compare channel: register map, field layout, mode codes.
// Assumes a plain byte-wide register port and a 16-bit timer outside.
package ccpcmp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_CONTROL  = 2'h0;
  localparam logic [1:0] ADDR_CMP_LOW  = 2'h1;
  localparam logic [1:0] ADDR_CMP_HIGH = 2'h2;
  localparam logic [1:0] ADDR_ALT_PIN  = 2'h3;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         MODE_LSB       = 0;
  localparam int         MODE_MSB       = 3;
  localparam int         DUTY_LSB       = 4;
  localparam int         DUTY_MSB       = 5;
  localparam int         ALT_SEL_BIT    = 0;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] CMP_RESET      = 8'h00;
  localparam logic [7:0] ALT_PIN_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_MASK   = 8'h3f;
  localparam logic [7:0] ALT_PIN_MASK   = 8'h01;

  // ----------------------------------------------------------------
  // Compare mode encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_TOGGLE    = 4'h2;
  localparam logic [3:0] MODE_SET       = 4'h8;
  localparam logic [3:0] MODE_CLEAR     = 4'h9;
  localparam logic [3:0] MODE_SOFT_INT  = 4'ha;
  localparam logic [3:0] MODE_SPECIAL   = 4'hb;

  typedef enum logic [1:0] {
    CCPCMP_ACT_NONE,
    CCPCMP_ACT_PIN,
    CCPCMP_ACT_INT,
    CCPCMP_ACT_TRIG
  } ccpcmp_act_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } ccpcmp_req_t;

  // Timer side view
  typedef struct packed {
    logic [15:0] count;
    logic        tick;
    logic        sys_clk_src;
  } ccpcmp_tmr_t;

endpackage : ccpcmp_pkg

/* ccpcmp_matcher.sv */
// Equality detector between compare value and timer count.
// Assumes both words are stable in the system clock domain.
module ccpcmp_matcher
(
  // Operands
  input  wire logic [15:0] cmp_value_i,
  input  wire logic [15:0] timer_count_i,
  input  wire logic        enable_i,
  // Result
  output logic             match_o
);

  // Evaluated on every timer value, not just on ticks
  assign match_o = enable_i && (cmp_value_i == timer_count_i);

endmodule : ccpcmp_matcher

/* ccpcmp_pin_load.sv */
// External load on one channel pin: a weak pull-down.
// Assumes the enable is high while the channel drives the pin.
module ccpcmp_pin_load
(
  // Channel drive
  input  wire logic drv_i,
  input  wire logic oe_i,
  // Level seen by the load
  output logic      level_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released line falls to the pull-down, never holds the last value
  assign level_o = oe_i ? drv_i : 1'b0;
endmodule : ccpcmp_pin_load

/* ccpcmp_compare_unit_sva.sv */
// Checker for the compare channel, bound to the top module ports.
// Assumes register writes land at the edge that takes the strobe.
module ccpcmp_compare_unit_sva
(
  // Clock, reset, register port
  input wire logic                    sys_clk_i,
  input wire logic                    reset_n_i,
  input wire ccpcmp_pkg::ccpcmp_req_t reg_req_i,
  input wire logic [7:0]              reg_rdata_o,
  // Timer, converter, flag, pin
  input wire ccpcmp_pkg::ccpcmp_tmr_t timer_i,
  input wire logic                    timer_reset_o,
  input wire logic                    timer_ovf_from_trig_o,
  input wire logic                    adc_enable_i,
  input wire logic                    adc_start_o,
  input wire logic                    flag_clear_i,
  input wire logic                    channel_interrupt_flag_o,
  input wire logic                    pin_direction_bit_i,
  input wire logic                    pin_main_oe_o,
  input wire logic                    pin_alt_oe_o,
  input wire logic                    special_trigger_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  ctl_q;
  logic [15:0] cmp_q;
  logic        alt_q;
  logic        eq_q;
  logic        eq;
  logic        act;
  assign eq  = (cmp_q == timer_i.count) && !timer_i.sys_clk_src;
  assign act = eq && !eq_q && (ctl_q[3:0] inside {4'h2, 4'h8, 4'h9, 4'ha, 4'hb});
  // ----
  // Shadow of the registers, so matches can be judged from the ports
  // ----
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctl_q <= 8'h00;
      cmp_q <= 16'h0000;
      alt_q <= 1'b0;
      eq_q  <= 1'b0;
    end
    else
    begin
      eq_q <= eq;
      if (reg_req_i.wr && reg_req_i.addr == 2'h0) ctl_q <= reg_req_i.wdata & 8'h3f;
      if (reg_req_i.wr && reg_req_i.addr == 2'h1) cmp_q[7:0] <= reg_req_i.wdata;
      if (reg_req_i.wr && reg_req_i.addr == 2'h2) cmp_q[15:8] <= reg_req_i.wdata;
      if (reg_req_i.wr && reg_req_i.addr == 2'h3) alt_q <= reg_req_i.wdata[0];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_TRIG_CAUSE: assert property (special_trigger_o |-> eq && ctl_q[3:0] == 4'hb)
    else $error("trigger without match");
  AST_ADC_START: assert property (adc_start_o == (special_trigger_o && adc_enable_i))
    else $error("converter start wrong");
  AST_NO_OVF: assert property (!timer_ovf_from_trig_o)
    else $error("overflow flag from trigger");
  AST_FLAG_SET: assert property (act |=> channel_interrupt_flag_o)
    else $error("flag not set on match");
  AST_FLAG_HOLD: assert property (channel_interrupt_flag_o && !flag_clear_i |=> channel_interrupt_flag_o)
    else $error("flag cleared by hardware");
  AST_TMR_RESET: assert property (timer_reset_o |-> timer_i.tick && eq && ctl_q[3:0] == 4'hb)
    else $error("timer reset without match at tick");
  AST_ALT_ROUTE: assert property (alt_q |-> !pin_main_oe_o && pin_alt_oe_o == !pin_direction_bit_i)
    else $error("alternate pin routing wrong");
  AST_CTL_READ: assert property (reg_req_i.rd && reg_req_i.addr == 2'h0 |=> reg_rdata_o == ctl_q)
    else $error("control read wrong");
  COV_TRIG: cover property (special_trigger_o ##1 timer_reset_o);
  COV_FLAG: cover property (act ##1 channel_interrupt_flag_o);
  COV_ALT: cover property (alt_q && pin_alt_oe_o);
endmodule : ccpcmp_compare_unit_sva
bind ccpcmp_compare_unit ccpcmp_compare_unit_sva u_sva (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .timer_i(timer_i), .timer_reset_o(timer_reset_o),
  .timer_ovf_from_trig_o(timer_ovf_from_trig_o), .adc_enable_i(adc_enable_i), .adc_start_o(adc_start_o),
  .flag_clear_i(flag_clear_i), .channel_interrupt_flag_o(channel_interrupt_flag_o),
  .pin_direction_bit_i(pin_direction_bit_i), .pin_main_oe_o(pin_main_oe_o), .pin_alt_oe_o(pin_alt_oe_o),
  .special_trigger_o(special_trigger_o));

/* tb_ccpcmp_compare_unit.sv */
// Self-checking bench for the compare channel.
// Assumes the bench drives the timer view and the register port.
module tb_ccpcmp_compare_unit;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  ccpcmp_pkg::ccpcmp_req_t req = '0;
  ccpcmp_pkg::ccpcmp_tmr_t tmr = '0;
  logic adc_en = 1'b0, fclr = 1'b0, dir = 1'b1, pdat = 1'b0;
  logic [7:0] rdata;
  logic trst, tovf, adcs, flag, pm, pmoe, pa, paoe, trig, lvl_m, lvl_a;
  int error_cnt = 0, checks = 0, cyc = 0;
  logic [3:0] modes [3] = '{4'h8, 4'h9, 4'h2};
  logic pins [3] = '{1'b1, 1'b0, 1'b1};
  always #5 sys_clk_i = ~sys_clk_i;
  ccpcmp_compare_unit u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .timer_i(tmr), .timer_reset_o(trst), .timer_ovf_from_trig_o(tovf),
    .adc_enable_i(adc_en), .adc_start_o(adcs), .flag_clear_i(fclr), .channel_interrupt_flag_o(flag),
    .pin_direction_bit_i(dir), .port_data_i(pdat), .pin_main_o(pm), .pin_main_oe_o(pmoe), .pin_alt_o(pa),
    .pin_alt_oe_o(paoe), .special_trigger_o(trig));
  ccpcmp_pin_load u_load (.drv_i(pm), .oe_i(pmoe), .level_o(lvl_m));
  ccpcmp_pin_load u_load_alt (.drv_i(pa), .oe_i(paoe), .level_o(lvl_a));
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    @(negedge sys_clk_i);
    chk(rdata, e);
  endtask : rd
  // Puts the timer on v and leaves it there; returns in the match cycle
  task automatic hit(input logic [15:0] v);
    @(posedge sys_clk_i);
    tmr.count <= v;
    @(negedge sys_clk_i);
  endtask : hit
  task automatic clr_flag();
    @(posedge sys_clk_i);
    fclr <= 1'b1;
    @(posedge sys_clk_i);
    fclr <= 1'b0;
    @(negedge sys_clk_i);
    chk(flag, 1'b0);
  endtask : clr_flag
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    wr(ccpcmp_pkg::ADDR_CONTROL, 8'hff);
    rd(ccpcmp_pkg::ADDR_CONTROL, 8'h3f);
    @(posedge sys_clk_i);
    dir  <= 1'b0;
    pdat <= 1'b1;
    wr(ccpcmp_pkg::ADDR_ALT_PIN, 8'hff);
    rd(ccpcmp_pkg::ADDR_ALT_PIN, 8'h01);
    chk({pmoe, paoe, lvl_a, lvl_m}, 8'h06);
    wr(ccpcmp_pkg::ADDR_ALT_PIN, 8'h00);
    wr(ccpcmp_pkg::ADDR_CMP_LOW, 8'h34);
    wr(ccpcmp_pkg::ADDR_CMP_HIGH, 8'h12);
    rd(ccpcmp_pkg::ADDR_CMP_HIGH, 8'h12);
    $display("test registers done");
    for (int i = 0; i < 3; i++)
    begin
      wr(ccpcmp_pkg::ADDR_CONTROL, {4'h0, modes[i]});
      hit(16'h1234);
      @(posedge sys_clk_i);
      tmr.count <= 16'h0000;
      @(negedge sys_clk_i);
      chk(lvl_m, pins[i]);
      chk(flag, 1'b1);
      clr_flag();
    end
    wr(ccpcmp_pkg::ADDR_CONTROL, 8'h00);
    wr(ccpcmp_pkg::ADDR_CONTROL, 8'h02);
    @(negedge sys_clk_i);
    chk(lvl_m, 1'b0);
    $display("test pin actions done");
    wr(ccpcmp_pkg::ADDR_CONTROL, 8'h0a);
    hit(16'h1234);
    chk(trig, 1'b0);
    @(posedge sys_clk_i);
    tmr.count <= 16'h0000;
    @(negedge sys_clk_i);
    chk({flag, lvl_m}, 8'h03);
    clr_flag();
    $display("test software interrupt done");
    @(posedge sys_clk_i);
    adc_en <= 1'b1;
    wr(ccpcmp_pkg::ADDR_CONTROL, 8'h0b);
    hit(16'h1234);
    chk({trig, adcs, trst, lvl_m}, 8'h0d);
    @(posedge sys_clk_i);
    tmr.tick <= 1'b1;
    @(negedge sys_clk_i);
    chk({trst, tovf, flag}, 8'h05);
    @(posedge sys_clk_i);
    tmr <= '0;
    clr_flag();
    hit(16'h1234);
    chk(trig, 1'b1);
    wr(ccpcmp_pkg::ADDR_CMP_LOW, 8'h35);
    tmr.tick <= 1'b1;
    @(negedge sys_clk_i);
    chk(trst, 1'b0);
    @(posedge sys_clk_i);
    tmr <= '0;
    clr_flag();
    // Timer on the raw system clock must never match
    @(posedge sys_clk_i);
    tmr.sys_clk_src <= 1'b1;
    hit(16'h1235);
    chk(trig, 1'b0);
    @(posedge sys_clk_i);
    tmr <= '0;
    @(negedge sys_clk_i);
    chk(flag, 1'b0);
    $display("test special trigger done");
    final_report();
  end
endmodule : tb_ccpcmp_compare_unit
